// ### sysctl_coproc_pkg.sv
package sysctl_coproc_pkg;

    // ------------------------------------------------------------------
    // Instruction field positions
    // ------------------------------------------------------------------
    localparam int COND_HI       = 31;
    localparam int COND_LO       = 28;
    localparam int CLASS_HI      = 27;
    localparam int CLASS_LO      = 24;
    localparam int OPC1_HI       = 23;
    localparam int OPC1_LO       = 21;
    localparam int DIR_BIT       = 20;
    localparam int TARGET_HI     = 19;
    localparam int TARGET_LO     = 16;
    localparam int CORE_REG_HI   = 15;
    localparam int CORE_REG_LO   = 12;
    localparam int CPNUM_HI      = 11;
    localparam int CPNUM_LO      = 8;
    localparam int OPC2_HI       = 7;
    localparam int OPC2_LO       = 5;
    localparam int XFER_BIT      = 4;
    localparam int EXTRA_HI      = 3;
    localparam int EXTRA_LO      = 0;

    // ------------------------------------------------------------------
    // Field codes
    // ------------------------------------------------------------------
    localparam logic [3:0] CLASS_XFER      = 4'hE;
    localparam logic [3:0] CPNUM_SYSCTL    = 4'hF;
    localparam logic [3:0] CLASS_LDST_HI   = 4'hC;
    localparam logic [2:0] CLASS_LDST_MASK = 3'h6;
    localparam logic       DIR_WRITE       = 1'b0;
    localparam logic       DIR_READ        = 1'b1;
    localparam logic [2:0] OPC1_SYSCTL     = 3'h0;
    localparam logic [3:0] PC_REG          = 4'hF;
    localparam logic [3:0] COND_NEVER      = 4'hF;

    // ------------------------------------------------------------------
    // Register locations
    // ------------------------------------------------------------------
    localparam logic [3:0] LOC_IDENT     = 4'h0;
    localparam logic [3:0] LOC_CONTROL   = 4'h1;
    localparam logic [3:0] LOC_TT_BASE   = 4'h2;
    localparam logic [3:0] LOC_DOMAIN    = 4'h3;
    localparam logic [3:0] LOC_FAULT_ST  = 4'h5;
    localparam logic [3:0] LOC_FAULT_AD  = 4'h6;
    localparam logic [3:0] LOC_CACHE_OP  = 4'h7;
    localparam logic [3:0] LOC_TB_OP     = 4'h8;
    localparam logic [3:0] LOC_LOCKDOWN  = 4'h9;
    localparam logic [3:0] LOC_TB_LOCK   = 4'hA;
    localparam logic [3:0] LOC_PROC_ID   = 4'hD;
    localparam logic [3:0] LOC_TEST_CFG  = 4'hF;

    // Secondary code and extra action selections
    localparam logic [2:0] OPC2_IDENTIFICATION    = 3'h0;
    localparam logic [2:0] OPC2_CACHE_TYPE = 3'h1;
    localparam logic [2:0] OPC2_TMEM_STAT  = 3'h2;
    localparam logic [2:0] OPC2_DATA_FAULT = 3'h0;
    localparam logic [2:0] OPC2_FETCH_FLT  = 3'h1;
    localparam logic [2:0] OPC2_RELOC      = 3'h0;
    localparam logic [2:0] OPC2_CONTEXT    = 3'h1;
    localparam logic [3:0] EXTRA_CACHE_LK  = 4'h0;
    localparam logic [3:0] EXTRA_TMEM_REG  = 4'h1;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_WORD           = 32'h0000_0000;
    localparam int          BRL_COMPRESSED_CYC = 4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BRL_FIRST,
        ST_BRL_SECOND
    } brl_state_t;

endpackage : sysctl_coproc_pkg

// ### system_control_coproc_access.sv
`timescale 1ns/1ns
// How it works
// RL1 - Transfers take effect only when the core reports a privileged mode; otherwise undefined.
// RL2 - A write transfer (direction bit 0) copies the core register word into the target register.
// RL3 - A read transfer (direction bit 1) returns the target register word to the core register.
// RL4 - Data-processing, load and store forms aimed at this coprocessor raise undefined.
// RL5 - A transfer has bits 27:24 = 1110, bits 11:8 = 1111, bit 4 = 1; cond 31:28, dir bit 20.
// RL6 - Bits 15:12 name the core register; choosing the program counter is left unpredictable.
// RL7 - Bits 19:16 pick the register location addressed.
// RL8 - Bits 3:0 carry an extra action whose meaning depends on the location.
// RL9 - Bits 7:5 carry a secondary code that refines the access, normally zero.
// RL10 - The primary code field in the upper bits is decoded as part of the transfer.
// RL11 - Locations 0, 5 and 13 pick among physical registers by the secondary code.
// RL12 - Location 9 picks cache lockdown or tight memory region by the extra action field.
// RL13 - Sixteen locations, 0 to 15, are exposed.
// RL14 - The compressed branch_link_exchange is two instructions taking four cycles.
// RL15 - Writes to read-only, reads of write-only and reserved accesses have no effect; reads 0.
// RL16 - Each transfer moves one full 32-bit word in a single operation.
module system_control_coproc_access #(
    parameter logic [31:0] IDENT_VALUE      = 32'h0000_0001, // Arbitrary value
    parameter logic [31:0] CACHE_TYPE_VALUE = 32'h0000_0002, // Arbitrary value
    parameter logic [31:0] TMEM_STAT_VALUE  = 32'h0000_0003  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Instruction issue from the core
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr,
    input  wire logic        cond_pass,
    input  wire logic        privileged,
    input  wire logic [31:0] core_reg_data,
    // Compressed branch_link_exchange issue
    input  wire logic        brl_compressed,
    // Answer to the core
    output logic             xfer_done,
    output logic             undef_instr,
    output logic             rd_valid,
    output logic [3:0]       rd_core_reg,
    output logic [31:0]      rd_data,
    output logic             brl_busy,
    output logic             brl_done,
    // Register contents toward the system
    output logic [31:0]      system_control,
    output logic [31:0]      translation_table_base,
    output logic [31:0]      domain_access_control,
    output logic             cache_op_pulse,
    output logic             tb_op_pulse,
    output logic [31:0]      maint_word,
    output logic [6:0]       maint_sel
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                   ctrl;
        logic [31:0]                   tt_base;
        logic [31:0]                   domain;
        logic [31:0]                   data_fault;
        logic [31:0]                   fetch_fault;
        logic [31:0]                   fault_addr;
        logic [31:0]                   cache_lock;
        logic [31:0]                   tmem_region;
        logic [31:0]                   tb_lock;
        logic [31:0]                   reloc;
        logic [31:0]                   context_identifier;
        logic [31:0]                   test_cfg;
        logic                          done;
        logic                          undef;
        logic                          rvalid;
        logic [3:0]                    rreg;
        logic [31:0]                   rdata;
        logic                          cache_pulse;
        logic                          tb_pulse;
        logic [31:0]                   mword;
        logic [6:0]                    msel;
        sysctl_coproc_pkg::brl_state_t brl;
        logic [1:0]                    brl_cnt;
        logic                          brl_fin;
        logic                          brl_run;
    } state_t;

    state_t cur;
    state_t next_cur;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_transfer(input logic [31:0] w);
        is_transfer = (w[sysctl_coproc_pkg::CLASS_HI:sysctl_coproc_pkg::CLASS_LO]
                       == sysctl_coproc_pkg::CLASS_XFER)
                   && (w[sysctl_coproc_pkg::CPNUM_HI:sysctl_coproc_pkg::CPNUM_LO]
                       == sysctl_coproc_pkg::CPNUM_SYSCTL)
                   && w[sysctl_coproc_pkg::XFER_BIT]; // see RL5
    endfunction : is_transfer

    function automatic logic is_other_cp(input logic [31:0] w);
        logic data_proc;
        logic ld_st;
        data_proc = (w[sysctl_coproc_pkg::CLASS_HI:sysctl_coproc_pkg::CLASS_LO]
                     == sysctl_coproc_pkg::CLASS_XFER) && !w[sysctl_coproc_pkg::XFER_BIT];
        ld_st     = (w[27:25] == sysctl_coproc_pkg::CLASS_LDST_MASK);
        is_other_cp = (data_proc || ld_st)
                   && (w[sysctl_coproc_pkg::CPNUM_HI:sysctl_coproc_pkg::CPNUM_LO]
                       == sysctl_coproc_pkg::CPNUM_SYSCTL); // see RL4
    endfunction : is_other_cp

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    logic [3:0] f_cond;
    logic [2:0] f_opc1;
    logic       f_dir;
    logic [3:0] f_target;
    logic [3:0] f_core;
    logic [2:0] f_opc2;
    logic [3:0] f_extra;

    assign f_cond   = instr[sysctl_coproc_pkg::COND_HI:sysctl_coproc_pkg::COND_LO];       // see RL5
    assign f_opc1   = instr[sysctl_coproc_pkg::OPC1_HI:sysctl_coproc_pkg::OPC1_LO];       // see RL10
    assign f_dir    = instr[sysctl_coproc_pkg::DIR_BIT];                                 // see RL5
    assign f_target = instr[sysctl_coproc_pkg::TARGET_HI:sysctl_coproc_pkg::TARGET_LO];   // see RL7
    assign f_core   = instr[sysctl_coproc_pkg::CORE_REG_HI:
                            sysctl_coproc_pkg::CORE_REG_LO];                     // see RL6
    assign f_opc2   = instr[sysctl_coproc_pkg::OPC2_HI:sysctl_coproc_pkg::OPC2_LO];       // see RL9
    assign f_extra  = instr[sysctl_coproc_pkg::EXTRA_HI:sysctl_coproc_pkg::EXTRA_LO];     // see RL8

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        take;
        logic        xfer;
        logic        wr;
        logic        rd;
        logic [31:0] rword;
        take  = 1'b0;
        xfer  = 1'b0;
        wr    = 1'b0;
        rd    = 1'b0;
        rword = sysctl_coproc_pkg::RST_WORD;
        next_cur             = cur;
        next_cur.done        = 1'b0;
        next_cur.undef       = 1'b0;
        next_cur.rvalid      = 1'b0;
        next_cur.cache_pulse = 1'b0;
        next_cur.tb_pulse    = 1'b0;
        next_cur.brl_fin     = 1'b0;

        take = instr_valid && cond_pass && (f_cond != sysctl_coproc_pkg::COND_NEVER);
        xfer = take && is_transfer(instr)
            && (f_opc1 == sysctl_coproc_pkg::OPC1_SYSCTL);                // see RL10
        if (take && (is_other_cp(instr) || (xfer && !privileged)
                     || (is_transfer(instr) && f_opc1 != sysctl_coproc_pkg::OPC1_SYSCTL))) begin
            next_cur.undef = 1'b1;                                        // see RL1
        end
        wr = xfer && privileged && (f_dir == sysctl_coproc_pkg::DIR_WRITE); // see RL2
        rd = xfer && privileged && (f_dir == sysctl_coproc_pkg::DIR_READ);  // see RL3

        // Read mux over the sixteen locations
        case (f_target)                                                   // see RL13
            sysctl_coproc_pkg::LOC_IDENT: begin
                case (f_opc2)                                             // see RL11
                    sysctl_coproc_pkg::OPC2_IDENTIFICATION:    rword = IDENT_VALUE;
                    sysctl_coproc_pkg::OPC2_CACHE_TYPE: rword = CACHE_TYPE_VALUE;
                    sysctl_coproc_pkg::OPC2_TMEM_STAT:  rword = TMEM_STAT_VALUE;
                    default:                            rword = IDENT_VALUE;
                endcase
            end
            sysctl_coproc_pkg::LOC_CONTROL:  rword = cur.ctrl;
            sysctl_coproc_pkg::LOC_TT_BASE:  rword = cur.tt_base;
            sysctl_coproc_pkg::LOC_DOMAIN:   rword = cur.domain;
            sysctl_coproc_pkg::LOC_FAULT_ST: begin
                rword = (f_opc2 == sysctl_coproc_pkg::OPC2_FETCH_FLT)
                      ? cur.fetch_fault : cur.data_fault;                 // see RL11
            end
            sysctl_coproc_pkg::LOC_FAULT_AD: rword = cur.fault_addr;
            sysctl_coproc_pkg::LOC_LOCKDOWN: begin
                rword = (f_extra == sysctl_coproc_pkg::EXTRA_TMEM_REG)
                      ? cur.tmem_region : cur.cache_lock;                 // see RL12
            end
            sysctl_coproc_pkg::LOC_TB_LOCK:  rword = cur.tb_lock;
            sysctl_coproc_pkg::LOC_PROC_ID: begin
                rword = (f_opc2 == sysctl_coproc_pkg::OPC2_CONTEXT)
                      ? cur.context_identifier : cur.reloc;                       // see RL11
            end
            sysctl_coproc_pkg::LOC_TEST_CFG: rword = cur.test_cfg;
            default:                         rword = sysctl_coproc_pkg::RST_WORD; // see RL15
        endcase

        if (wr) begin
            case (f_target)                                               // see RL16
                sysctl_coproc_pkg::LOC_CONTROL:  next_cur.ctrl    = core_reg_data;
                sysctl_coproc_pkg::LOC_TT_BASE:  next_cur.tt_base = core_reg_data;
                sysctl_coproc_pkg::LOC_DOMAIN:   next_cur.domain  = core_reg_data;
                sysctl_coproc_pkg::LOC_FAULT_ST: begin
                    if (f_opc2 == sysctl_coproc_pkg::OPC2_FETCH_FLT) begin
                        next_cur.fetch_fault = core_reg_data;             // see RL11
                    end else begin
                        next_cur.data_fault = core_reg_data;
                    end
                end
                sysctl_coproc_pkg::LOC_FAULT_AD: next_cur.fault_addr = core_reg_data;
                sysctl_coproc_pkg::LOC_CACHE_OP,
                sysctl_coproc_pkg::LOC_TB_OP: begin
                    next_cur.cache_pulse = (f_target == sysctl_coproc_pkg::LOC_CACHE_OP);
                    next_cur.tb_pulse    = (f_target == sysctl_coproc_pkg::LOC_TB_OP);
                    next_cur.mword       = core_reg_data;
                    next_cur.msel        = {f_opc2, f_extra};             // see RL8
                end
                sysctl_coproc_pkg::LOC_LOCKDOWN: begin
                    if (f_extra == sysctl_coproc_pkg::EXTRA_TMEM_REG) begin
                        next_cur.tmem_region = core_reg_data;             // see RL12
                    end else begin
                        next_cur.cache_lock = core_reg_data;
                    end
                end
                sysctl_coproc_pkg::LOC_TB_LOCK:  next_cur.tb_lock = core_reg_data;
                sysctl_coproc_pkg::LOC_PROC_ID: begin
                    if (f_opc2 == sysctl_coproc_pkg::OPC2_CONTEXT) begin
                        next_cur.context_identifier = core_reg_data;              // see RL11
                    end else begin
                        next_cur.reloc = core_reg_data;
                    end
                end
                sysctl_coproc_pkg::LOC_TEST_CFG: next_cur.test_cfg = core_reg_data;
                default: ;                                                // see RL15
            endcase
        end

        if (wr || rd) begin
            next_cur.done = 1'b1;
        end
        if (rd) begin
            next_cur.rvalid = 1'b1;                                       // see RL3
            next_cur.rreg   = f_core;                                     // see RL6
            next_cur.rdata  = rword;
        end

        // Compressed branch_link_exchange: two halves, four cycles in all
        case (cur.brl)
            sysctl_coproc_pkg::ST_IDLE: begin
                if (brl_compressed) begin
                    next_cur.brl     = sysctl_coproc_pkg::ST_BRL_FIRST;   // see RL14
                    next_cur.brl_cnt = 2'(sysctl_coproc_pkg::BRL_COMPRESSED_CYC - 2);
                end
            end
            sysctl_coproc_pkg::ST_BRL_FIRST: begin
                next_cur.brl = sysctl_coproc_pkg::ST_BRL_SECOND;
            end
            sysctl_coproc_pkg::ST_BRL_SECOND: begin
                if (cur.brl_cnt == 2'h0) begin
                    next_cur.brl     = sysctl_coproc_pkg::ST_IDLE;
                end else begin
                    next_cur.brl_cnt = cur.brl_cnt - 2'h1;
                    // Done shows in the last busy cycle
                    next_cur.brl_fin = (cur.brl_cnt == 2'h1);             // see RL14
                end
            end
            default: next_cur.brl = sysctl_coproc_pkg::ST_IDLE;
        endcase
        next_cur.brl_run = (next_cur.brl != sysctl_coproc_pkg::ST_IDLE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            cur     <= '0;
            cur.brl <= sysctl_coproc_pkg::ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign xfer_done              = cur.done;
    assign undef_instr            = cur.undef;
    assign rd_valid               = cur.rvalid;
    assign rd_core_reg            = cur.rreg;
    assign rd_data                = cur.rdata;
    assign brl_busy               = cur.brl_run;
    assign brl_done               = cur.brl_fin;
    assign system_control         = cur.ctrl;
    assign translation_table_base = cur.tt_base;
    assign domain_access_control  = cur.domain;
    assign cache_op_pulse         = cur.cache_pulse;
    assign tb_op_pulse            = cur.tb_pulse;
    assign maint_word             = cur.mword;
    assign maint_sel              = cur.msel;

endmodule : system_control_coproc_access

// ### sysctl_coproc_checker.sv
`timescale 1ns/1ns
module sysctl_coproc_checker (
    // Clock, reset and issue side
    input wire logic        clk, srst, instr_valid, cond_pass, privileged, brl_compressed,
    input wire logic [31:0] instr, core_reg_data,
    // Answer side
    input wire logic        xfer_done, undef_instr, rd_valid, brl_busy, brl_done,
    input wire logic        cache_op_pulse, tb_op_pulse,
    input wire logic [3:0]  rd_core_reg,
    input wire logic [31:0] rd_data, system_control, translation_table_base,
    input wire logic [31:0] domain_access_control, maint_word,
    input wire logic [6:0]  maint_sel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // ------------------------------------------------------------------
    // Decoded request
    // ------------------------------------------------------------------
    wire logic tk  = instr_valid && cond_pass && instr[31:28] != 4'hF;
    wire logic cpx = tk && instr[27:24] == 4'hE && instr[11:8] == 4'hF;
    wire logic xf  = cpx && instr[4];
    wire logic ok  = xf && privileged && instr[23:21] == 3'h0;
    wire logic wr  = ok && !instr[20];

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_unpriv_refused: assert property (xf && !privileged |=> undef_instr && !xfer_done)
        else $error("unprivileged transfer not refused");
    a_write_control: assert property (wr && instr[19:16] == 4'h1 |=> xfer_done
        && system_control == $past(core_reg_data))
        else $error("write to control word lost");
    a_read_answer: assert property (ok && instr[20] |=> rd_valid
        && rd_core_reg == $past(instr[15:12]))
        else $error("read answer wrong");
    a_cdp_refused: assert property (cpx && privileged && !instr[4] |=> undef_instr)
        else $error("data processing form not refused");
    a_ldst_refused: assert property (tk && instr[27:25] == 3'h6
        && instr[11:8] == 4'hF |=> undef_instr)
        else $error("load or store form not refused");
    a_idle_quiet: assert property (!tk |=> !xfer_done && !undef_instr && !rd_valid)
        else $error("answer without taken instruction");
    a_opc1_refused: assert property (xf && privileged && instr[23:21] != 3'h0
        |=> undef_instr && !xfer_done)
        else $error("nonzero primary code not refused");
    a_ttb_target: assert property (wr && instr[19:16] == 4'h2 |=>
        translation_table_base == $past(core_reg_data) && $stable(domain_access_control))
        else $error("table base write misrouted");
    a_maint_fields: assert property (wr && instr[19:16] == 4'h7 |=> cache_op_pulse
        && maint_sel == {$past(instr[7:5]), $past(instr[3:0])})
        else $error("maintenance fields wrong");
    a_tb_read_zero: assert property (ok && instr[20] && instr[19:16] == 4'h8
        |=> rd_data == 32'h0)
        else $error("write-only location read nonzero");
    a_brl_four: assert property (brl_compressed && !brl_busy |=>
        (brl_busy && !brl_done) [*3] ##1 (brl_busy && brl_done) ##1 !brl_busy)
        else $error("compressed branch timing wrong");

    c_read: cover property (ok && instr[20]);
    c_write: cover property (wr);
    c_undef: cover property (undef_instr);
    c_brl: cover property (brl_done);
endmodule : sysctl_coproc_checker

bind system_control_coproc_access sysctl_coproc_checker chk (.*);

// ### core_issue_model.sv
`timescale 1ns/1ns
module core_issue_model (
    // Clock
    input  wire logic        clk,
    // Instruction issue
    output logic             instr_valid,
    output logic [31:0]      instr,
    output logic             cond_pass,
    output logic             privileged,
    output logic [31:0]      core_reg_data
);
    initial begin
        instr_valid = 1'b0;
        instr = 32'h0;
        cond_pass = 1'b0;
        privileged = 1'b1;
        core_reg_data = 32'h0;
    end

    // One instruction for one cycle, then the idle bus is scrambled
    task automatic issue(input logic [31:0] w, input logic [31:0] d, input logic pv,
                         input logic cp);
        @(negedge clk);
        instr_valid = 1'b1;
        instr = w;
        cond_pass = cp;
        privileged = pv;
        core_reg_data = d;
        @(negedge clk);
        instr_valid = 1'b0;
        instr = ~w;
        cond_pass = ~cp;
        core_reg_data = ~d;
    endtask : issue
endmodule : core_issue_model

// ### system_control_coproc_access_tb.sv
`timescale 1ns/1ns
module system_control_coproc_access_tb;
    localparam logic [31:0] ID_V = 32'h0000_00A5; // Arbitrary value
    localparam logic [31:0] CT_V = 32'h0000_0B6C; // Arbitrary value
    localparam logic [31:0] TS_V = 32'h0000_0C7D; // Arbitrary value
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        brl_compressed = 1'b0;
    logic        instr_valid, cond_pass, privileged, xfer_done, undef_instr, rd_valid;
    logic        brl_busy, brl_done, cache_op_pulse, tb_op_pulse;
    logic [3:0]  rd_core_reg;
    logic [6:0]  maint_sel;
    logic [31:0] instr, core_reg_data, rd_data, system_control, translation_table_base;
    logic [31:0] domain_access_control, maint_word;
    logic [31:0] mreg [int];
    int          bad_count = 0;
    int          n_compared = 0;
    int          i, k;

    always #5 clk = ~clk;

    core_issue_model core (.*);
    system_control_coproc_access #(.IDENT_VALUE(ID_V), .CACHE_TYPE_VALUE(CT_V),
                                   .TMEM_STAT_VALUE(TS_V)) dut (.*);

    // ------------------------------------------------------------------
    // Reference model and checks
    // ------------------------------------------------------------------
    function automatic int key(input logic [31:0] w);
        int sub;
        sub = (w[19:16] inside {4'h5, 4'hD}) ? int'(w[7:5] == 3'h1) :
              (w[19:16] == 4'h9) ? int'(w[3:0] == 4'h1) : 0;
        return int'(w[19:16]) * 2 + sub;
    endfunction : key

    function automatic logic [31:0] mv(input int k);
        return mreg.exists(k) ? mreg[k] : 32'h0;
    endfunction : mv

    function automatic logic [31:0] exp_rd(input logic [31:0] w);
        case (w[19:16])
            4'h0: return (w[7:5] == 3'h1) ? CT_V : (w[7:5] == 3'h2) ? TS_V : ID_V;
            4'h4, 4'h7, 4'h8, 4'hB, 4'hC, 4'hE: return 32'h0;
            default: return mv(key(w));
        endcase
    endfunction : exp_rd

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic xfer(input logic [3:0] loc, input logic dir, input logic [2:0] op2,
                        input logic [3:0] ex, input logic [31:0] d, input logic pv,
                        input logic [2:0] op1);
        logic [31:0] w;
        logic        ok;
        w = {8'hEE, op1, dir, loc, 4'($urandom_range(14)), 4'hF, op2, 1'b1, ex};
        ok = pv && op1 == 3'h0;
        core.issue(w, d, pv, 1'b1);
        cmp("xfer_done", 32'(ok), 32'(xfer_done));
        cmp("undef_instr", 32'(!ok), 32'(undef_instr));
        cmp("rd_valid", 32'(ok && dir), 32'(rd_valid));
        if (ok && dir) begin
            cmp("rd_data", exp_rd(w), rd_data);
            cmp("rd_core_reg", 32'(w[15:12]), 32'(rd_core_reg));
        end
        if (ok && !dir && loc inside {1, 2, 3, 5, 6, 9, 10, 13, 15}) mreg[key(w)] = d;
        if (ok && !dir && loc inside {7, 8}) begin
            cmp("cache_op_pulse", 32'(loc == 4'h7), 32'(cache_op_pulse));
            cmp("tb_op_pulse", 32'(loc == 4'h8), 32'(tb_op_pulse));
            cmp("maint_word", d, maint_word);
            cmp("maint_sel", 32'({op2, ex}), 32'(maint_sel));
        end
        cmp("system_control", mv(2), system_control);
        cmp("translation_table_base", mv(4), translation_table_base);
        cmp("domain_access_control", mv(6), domain_access_control);
    endtask : xfer

    task automatic raw(input logic [31:0] w, input logic cp, input logic ud);
        logic [31:0] sc;
        sc = system_control;
        core.issue(w, 32'hFFFF_FFFF, 1'b1, cp);
        cmp("undef_instr", 32'(ud), 32'(undef_instr));
        cmp("xfer_done", 32'h0, 32'(xfer_done | rd_valid));
        cmp("system_control", sc, system_control);
    endtask : raw

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h24E6));
        repeat (4) @(negedge clk);
        srst = 1'b0;
        for (i = 0; i < 16; i++) xfer(4'(i), 1'b1, 3'h0, 4'h0, 32'h0, 1'b1, 3'h0);
        for (i = 0; i < 3; i++) xfer(4'h0, 1'b1, 3'(i), 4'h0, 32'h0, 1'b1, 3'h0);
        for (i = 0; i < 32; i++) xfer(4'(i / 2), 1'(i % 2), 3'(i % 2), 4'(i % 2), $urandom,
                                      1'b1, 3'h0);
        for (i = 0; i < 32; i++) xfer(4'(i / 2), 1'b1, 3'(i % 2), 4'(i % 2), 32'h0,
                                      1'b1, 3'h0);
        repeat (60) xfer(4'($urandom_range(15)), 1'($urandom_range(1)), 3'($urandom_range(2)),
                         4'($urandom_range(1)), $urandom, 1'b1, 3'h0);
        xfer(4'h1, 1'b0, 3'h0, 4'h0, $urandom, 1'b0, 3'h0);
        xfer(4'h1, 1'b1, 3'h0, 4'h0, 32'h0, 1'b0, 3'h0);
        for (i = 1; i < 8; i++) xfer(4'h2, 1'b0, 3'h0, 4'h0, $urandom, 1'b1, 3'(i));
        raw(32'hEE01_3F00, 1'b1, 1'b1);
        raw(32'hEC81_3F00, 1'b1, 1'b1);
        raw(32'hED01_3F00, 1'b1, 1'b1);
        raw(32'hEE01_3E10, 1'b1, 1'b0);
        raw(32'hFE01_3F10, 1'b1, 1'b0);
        raw(32'hEE01_3F10, 1'b0, 1'b0);
        @(negedge clk);
        brl_compressed = 1'b1;
        @(negedge clk);
        k = 0;
        i = 0;
        while (brl_busy === 1'b1 && k < 9) begin
            k++;
            if (brl_done === 1'b1) i = k;
            if (k == 2) brl_compressed = 1'b0;
            @(negedge clk);
        end
        cmp("brl_busy_cycles", 32'd4, 32'(k));
        cmp("brl_done_cycle", 32'd4, 32'(i));
        test_done();
    end

    initial begin
        #100000;
        bad_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        test_done();
    end
endmodule : system_control_coproc_access_tb
